/* rtl/posmode_pkg.sv */
package posmode_pkg;
    // Operating modes selected by the controller
    typedef enum logic [1:0] {
        MODE_NONE = 2'b00,
        MODE_STEP = 2'b01,
        MODE_REF  = 2'b10,
        MODE_JOG  = 2'b11
    } mode_type;

    // Channel state
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ACTIVE  = 2'b01,
        ST_MOVING  = 2'b10,
        ST_STOPPED = 2'b11
    } state_type;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CMD    = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_CFG    = 8'h0c;

    // Control register fields
    localparam int CTRL_MODE_LO  = 0;
    localparam int CTRL_PERMIT   = 2;
    localparam int CTRL_ACK      = 3;
    // Command register fields, written as one-shot requests
    localparam int CMD_START     = 0;
    localparam int CMD_DIR_P     = 1;
    localparam int CMD_DIR_M     = 2;
    localparam int CMD_STOP      = 3;
    localparam int CMD_ARRIVED   = 4;
    // Status register fields
    localparam int ST_FAULT      = 0;
    localparam int ST_STEP_ACT   = 1;
    localparam int ST_RUNNING    = 2;
    localparam int ST_REACHED    = 3;
    localparam int ST_PERMIT     = 4;
    localparam int ST_DIR_POS    = 5;
    localparam int ST_ACCEPT     = 6;
    localparam int ST_MODE_LO    = 8;
    // Configuration fields: which start commands are allowed, and rotary axis for plain-start direction
    localparam int CFG_AUTO_OK   = 0;
    localparam int CFG_DIR_OK    = 1;
    localparam int CFG_ROTARY    = 2;
    localparam logic [2:0] CFG_RESET = 3'b011;
endpackage

/* rtl/positioning_mode_command.sv */
`timescale 1ns/10ps
// Overview of operation
// RULE_01: Target-stepping mode approaches predefined targets
// RULE_02: Reference seek mode and hold-to-run jog mode
// RULE_03: Controller keeps one mode active
// RULE_04: Each channel commanded separately
// RULE_05: Setpoints loaded before mode request
// RULE_06: Controller services mode until it ends
// RULE_07: Accepted starts depend on configuration, axis
// RULE_08: Plain start, device picks direction
// RULE_09: Direction commands start negative or positive
// RULE_10: Stop ends mode and positioning task; code only goes to ST_STOPPED, mode stays selected
// RULE_11: Fault on illegal mode entry or control
// RULE_12: Pending fault blocks start and resume
// RULE_13: Controller acknowledges fault with one
// RULE_14: Controller clears command after acceptance
// RULE_15: Jog direction commands held, not cleared
// RULE_16: Drive permit output follows permit input
// RULE_17: Step-active flag confirms stepping mode entered
// RULE_18: Losing drive permit aborts positioning
// RULE_19: Target reached set on arrival, cleared on start
// RULE_20: Command accepted once, acceptance signalled
module positioning_mode_command (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             drive_permit,
    output logic             motion_pos,
    output logic             motion_neg
);
    typedef struct packed {
        posmode_pkg::mode_type  mode;
        posmode_pkg::state_type state;
        logic        permit_in;
        logic        fault_ack;
        logic        fault;
        logic        step_act;
        logic        reached;
        logic        dir_pos;
        logic        accept;
        logic        jog_p;
        logic        jog_m;
        logic [2:0]  cfg;
        logic        drive_permit;
        logic        motion_pos;
        logic        motion_neg;
        logic [31:0] prdata;
        logic        pslverr;
        logic        pready;
    } regs_type;

    regs_type r, n;
    logic acc, pend, wr, rd, hit, jog_hold;
    logic start_req, dp_req, dm_req, stop_req, arrive, any_start, ok;
    posmode_pkg::mode_type wmode;

    // One wait state: the first access cycle loads the answer, so read data
    // already stands when pready is seen high; writes land on that same edge
    assign pend = psel & penable & ~r.pready;
    assign acc  = psel & penable & r.pready;
    assign wr   = acc & pwrite;
    assign rd   = pend & ~pwrite;
    assign hit = (paddr == posmode_pkg::OFS_CTRL) | (paddr == posmode_pkg::OFS_CMD) |
                 (paddr == posmode_pkg::OFS_STATUS) | (paddr == posmode_pkg::OFS_CFG);
    assign wmode = posmode_pkg::mode_type'(pwdata[posmode_pkg::CTRL_MODE_LO +: 2]);
    assign start_req = wr & (paddr == posmode_pkg::OFS_CMD) & pwdata[posmode_pkg::CMD_START];
    assign dp_req    = wr & (paddr == posmode_pkg::OFS_CMD) & pwdata[posmode_pkg::CMD_DIR_P];
    assign dm_req    = wr & (paddr == posmode_pkg::OFS_CMD) & pwdata[posmode_pkg::CMD_DIR_M];
    assign stop_req  = wr & (paddr == posmode_pkg::OFS_CMD) & pwdata[posmode_pkg::CMD_STOP];
    assign arrive    = wr & (paddr == posmode_pkg::OFS_CMD) & pwdata[posmode_pkg::CMD_ARRIVED];
    assign any_start = start_req | dp_req | dm_req;
    // A held jog direction rewritten while moving is service, not a new start
    assign jog_hold  = (r.mode == posmode_pkg::MODE_JOG) &
                       (r.state == posmode_pkg::ST_MOVING) & ~start_req &
                       ((dp_req & r.jog_p & ~dm_req) | (dm_req & r.jog_m & ~dp_req));

    // Next-state logic for mode, commands, fault and bus answer
    always_comb begin
        n = r;
        n.accept = 1'b0;
        ok = 1'b1;
        // Control register write: mode select, permit, acknowledge
        if (wr && paddr == posmode_pkg::OFS_CTRL) begin
            n.permit_in = pwdata[posmode_pkg::CTRL_PERMIT];
            n.fault_ack = pwdata[posmode_pkg::CTRL_ACK];
            if (wmode != r.mode) begin
                // Mode change only from rest and fault-free; a second mode while moving is refused
                if (r.fault || r.state == posmode_pkg::ST_MOVING) begin
                    n.fault = 1'b1; // RULE_11
                end else begin
                    n.mode = wmode; // RULE_01 RULE_02
                    n.state = (wmode == posmode_pkg::MODE_NONE) ? posmode_pkg::ST_IDLE
                                                                 : posmode_pkg::ST_ACTIVE;
                    n.step_act = (wmode == posmode_pkg::MODE_STEP); // RULE_17
                end
            end
        end
        if (wr && paddr == posmode_pkg::OFS_CFG) begin
            n.cfg = pwdata[2:0];
        end
        // Acknowledge level clears the fault; new faults below still win
        if (r.fault_ack) begin
            n.fault = 1'b0; // RULE_13
        end
        // Drive permit output tracks the permit input
        n.drive_permit = r.permit_in; // RULE_16
        // Start and direction commands
        if (any_start && !jog_hold) begin
            ok = (start_req && r.cfg[posmode_pkg::CFG_AUTO_OK]) ||
                 ((dp_req || dm_req) && r.cfg[posmode_pkg::CFG_DIR_OK]); // RULE_07
            if (dp_req && dm_req) ok = 1'b0;
            if (r.fault || r.mode == posmode_pkg::MODE_NONE || !r.permit_in ||
                r.state == posmode_pkg::ST_MOVING) ok = 1'b0; // RULE_12
            if (ok) begin
                n.state = posmode_pkg::ST_MOVING;
                n.accept = 1'b1; // RULE_20
                n.reached = 1'b0; // RULE_19
                if (dp_req) n.dir_pos = 1'b1; // RULE_09
                else if (dm_req) n.dir_pos = 1'b0; // RULE_09
                else n.dir_pos = r.cfg[posmode_pkg::CFG_ROTARY] ? r.dir_pos : 1'b1; // RULE_08
                n.jog_p = dp_req & (r.mode == posmode_pkg::MODE_JOG);
                n.jog_m = dm_req & (r.mode == posmode_pkg::MODE_JOG);
            end else begin
                n.fault = 1'b1; // RULE_11
            end
        end
        // Jog runs only while the held direction command is rewritten each service
        if (r.mode == posmode_pkg::MODE_JOG && r.state == posmode_pkg::ST_MOVING &&
            wr && paddr == posmode_pkg::OFS_CMD && !(dp_req && r.jog_p) && !(dm_req && r.jog_m)) begin
            n.state = posmode_pkg::ST_STOPPED; // RULE_15
            n.jog_p = 1'b0;
            n.jog_m = 1'b0;
        end
        // Arrival report ends the approach at target
        if (arrive && r.state == posmode_pkg::ST_MOVING && !any_start) begin
            n.state = posmode_pkg::ST_ACTIVE;
            n.reached = 1'b1; // RULE_19
        end
        // Stop and permit loss abort; both beat a start in the same cycle
        if (stop_req && r.state != posmode_pkg::ST_IDLE) begin
            n.state = posmode_pkg::ST_STOPPED; // RULE_10
            n.accept = 1'b0;
            n.jog_p = 1'b0;
            n.jog_m = 1'b0;
        end
        if (!r.permit_in && r.state == posmode_pkg::ST_MOVING) begin
            n.state = posmode_pkg::ST_STOPPED; // RULE_18
            n.jog_p = 1'b0;
            n.jog_m = 1'b0;
        end
        n.motion_pos = (n.state == posmode_pkg::ST_MOVING) & n.dir_pos;
        n.motion_neg = (n.state == posmode_pkg::ST_MOVING) & ~n.dir_pos;
        // Read data and error answer
        n.prdata = 32'h0000_0000;
        n.pslverr = pend & ~hit;
        n.pready = pend;
        if (rd) begin
            unique case (paddr)
                posmode_pkg::OFS_CTRL: begin
                    n.prdata[posmode_pkg::CTRL_MODE_LO +: 2] = r.mode;
                    n.prdata[posmode_pkg::CTRL_PERMIT] = r.permit_in;
                    n.prdata[posmode_pkg::CTRL_ACK] = r.fault_ack;
                end
                posmode_pkg::OFS_STATUS: begin
                    n.prdata[posmode_pkg::ST_FAULT] = r.fault;
                    n.prdata[posmode_pkg::ST_STEP_ACT] = r.step_act;
                    n.prdata[posmode_pkg::ST_RUNNING] = (r.state == posmode_pkg::ST_MOVING);
                    n.prdata[posmode_pkg::ST_REACHED] = r.reached;
                    n.prdata[posmode_pkg::ST_PERMIT] = r.drive_permit;
                    n.prdata[posmode_pkg::ST_DIR_POS] = r.dir_pos;
                    n.prdata[posmode_pkg::ST_ACCEPT] = r.accept;
                    n.prdata[posmode_pkg::ST_MODE_LO +: 2] = r.state;
                end
                posmode_pkg::OFS_CFG: n.prdata[2:0] = r.cfg;
                default: n.prdata = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.cfg <= posmode_pkg::CFG_RESET;
        end else begin
            r <= n;
        end
    end

    assign prdata       = r.prdata;
    assign pready       = r.pready;
    assign pslverr      = r.pslverr;
    assign drive_permit = r.drive_permit;
    assign motion_pos   = r.motion_pos;
    assign motion_neg   = r.motion_neg;

    // Checks
    a_fault_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        (r.fault && any_start) |=> (r.state == $past(r.state) || r.state == posmode_pkg::ST_STOPPED)
                                   && !r.accept) else $error("start taken during fault"); // RULE_12
    a_permit_follow: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 drive_permit == $past(r.permit_in)) else $error("permit not followed"); // RULE_16
    a_permit_abort: assert property (@(posedge pclk) disable iff (!presetn)
        (!r.permit_in && r.state == posmode_pkg::ST_MOVING) |=> r.state != posmode_pkg::ST_MOVING)
        else $error("permit loss no abort"); // RULE_18
    a_stop_ends: assert property (@(posedge pclk) disable iff (!presetn)
        (stop_req && r.state != posmode_pkg::ST_IDLE) |=> r.state == posmode_pkg::ST_STOPPED)
        else $error("stop ignored"); // RULE_10
    a_accept_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        r.accept |=> !r.accept) else $error("accept longer than one cycle"); // RULE_20
    a_step_flag: assert property (@(posedge pclk) disable iff (!presetn)
        r.step_act |-> r.mode == posmode_pkg::MODE_STEP) else $error("step flag wrong"); // RULE_17
    a_reach_clear: assert property (@(posedge pclk) disable iff (!presetn)
        r.accept |-> !r.reached) else $error("reached not cleared"); // RULE_19
    a_dir_set: assert property (@(posedge pclk) disable iff (!presetn)
        (dp_req && !dm_req && !stop_req && r.permit_in && ok) |=> r.dir_pos && motion_pos)
        else $error("positive start wrong"); // RULE_09
    a_bad_start: assert property (@(posedge pclk) disable iff (!presetn)
        (any_start && !ok) |=> r.fault) else $error("fault not raised"); // RULE_11
    c_step_run: cover property (@(posedge pclk) r.step_act ##1 r.accept);
    c_reach: cover property (@(posedge pclk) r.accept ##[1:50] r.reached);
    c_fault_ack: cover property (@(posedge pclk) r.fault ##[1:20] !r.fault);
endmodule

/* verification/apb_controller_model.sv */
`timescale 1ns/10ps
// Controlling program: one APB transfer at a time, held until pready
module apb_controller_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    logic [31:0] rd_data;
    logic        rd_err;
    // Idle bus from time zero so the slave never sees an unknown select
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Answer is taken at the edge that samples pready high, then released
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

/* verification/tb_positioning_mode_command.sv */
`timescale 1ns/10ps
module tb_positioning_mode_command;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic [4:0]  st;
        logic [1:0]  mo;
    } row_type;
    localparam logic [7:0] ct = posmode_pkg::OFS_CTRL;
    localparam logic [7:0] cm = posmode_pkg::OFS_CMD;
    localparam logic [7:0] sr = posmode_pkg::OFS_STATUS;
    localparam logic [7:0] cf = posmode_pkg::OFS_CFG;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        drive_permit, motion_pos, motion_neg;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    int          fails, total_checks, cycles;
    // Status bits fault..permit, then {pos,neg} motion; one mode at a time
    row_type rows [23] = '{
        '{ct, 32'h5, 5'h12, 2'h0}, '{cm, 32'h1, 5'h16, 2'h2},
        '{cm, 32'h10, 5'h1a, 2'h0}, '{cm, 32'h4, 5'h16, 2'h1},
        '{cm, 32'h8, 5'h12, 2'h0}, '{cm, 32'h6, 5'h13, 2'h0},
        '{cm, 32'h1, 5'h13, 2'h0}, '{ct, 32'hd, 5'h12, 2'h0},
        '{ct, 32'h5, 5'h12, 2'h0}, '{cm, 32'h2, 5'h16, 2'h2},
        '{ct, 32'h1, 5'h02, 2'h0}, '{cm, 32'h1, 5'h03, 2'h0},
        '{ct, 32'hd, 5'h12, 2'h0}, '{ct, 32'h6, 5'h10, 2'h0},
        '{cm, 32'h4, 5'h14, 2'h1}, '{cm, 32'h8, 5'h10, 2'h0},
        '{ct, 32'h7, 5'h10, 2'h0}, '{cm, 32'h2, 5'h14, 2'h2},
        '{cm, 32'h2, 5'h14, 2'h2}, '{cm, 32'h0, 5'h10, 2'h0},
        '{cf, 32'h0, 5'h10, 2'h0}, '{cm, 32'h1, 5'h11, 2'h0},
        '{ct, 32'hf, 5'h10, 2'h0}};
    positioning_mode_command dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .drive_permit(drive_permit), .motion_pos(motion_pos), .motion_neg(motion_neg));
    apb_controller_model ctl_u (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr));
    // Compare and count; four-state equality so an unknown never matches
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Status read, masking the direction bit, the one-cycle accept pulse and the state field
    task automatic check_row(input row_type r);
        ctl_u.xfer(1'b0, sr, 32'h0);
        check(ctl_u.rd_data & 32'h1f, {27'h0, r.st});
        check({30'h0, motion_pos, motion_neg}, {30'h0, r.mo});
        check({31'h0, drive_permit}, {31'h0, r.st[4]});
    endtask
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails = fails + 1;
            finish_test();
        end
    end
    initial begin
        fails = 0;
        total_checks = 0;
        cycles = 0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        check_row('{sr, 32'h0, 5'h00, 2'h0});
        ctl_u.xfer(1'b0, cf, 32'h0);
        check(ctl_u.rd_data, 32'h3);
        for (int i = 0; i < 23; i++) begin
            ctl_u.xfer(1'b1, rows[i].a, rows[i].d);
            check_row(rows[i]);
        end
        // Unmapped place is refused, command register reads back empty
        ctl_u.xfer(1'b0, 8'h10, 32'h0);
        check({31'h0, ctl_u.rd_err}, 32'h1);
        ctl_u.xfer(1'b0, cm, 32'h0);
        check(ctl_u.rd_data, 32'h0);
        ctl_u.xfer(1'b0, ct, 32'h0);
        check(ctl_u.rd_data, 32'hf);
        // Reset in mid-motion drops every output
        ctl_u.xfer(1'b1, cf, 32'h3);
        ctl_u.xfer(1'b1, cm, 32'h2);
        @(posedge pclk);
        check({31'h0, motion_pos}, 32'h1);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        check_row('{sr, 32'h0, 5'h00, 2'h0});
        finish_test();
    end
endmodule
